/* File: logic/mprc_cond_if.sv */
`timescale 1ns/1ps
`include "mprc_map.svh"

interface mprc_cond_if;
  logic [`MPRC_IN_W-1:0] level;
  logic [`MPRC_IN_W-1:0] fall;
  logic [`MPRC_IN_W-1:0] rise;

  modport cond (output level, output fall, output rise);
  modport user (input level, input fall, input rise);
endinterface : mprc_cond_if

/* File: logic/mprc_map.svh */
`ifndef MPRC_MAP_SVH
`define MPRC_MAP_SVH

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MPRC_CLK_MHZ        50
`define MPRC_RST_PULSE_US   1000
`define MPRC_NOTICE_US      10
`define MPRC_RST_CNT_W      17
`define MPRC_NTC_CNT_W      10

// ---------------------------------------------------------------
// conditioned input positions and reset levels
// ---------------------------------------------------------------
`define MPRC_IN_W           5
`define MPRC_IN_PWR         0
`define MPRC_IN_RST         1
`define MPRC_IN_SUPPLY      2
`define MPRC_IN_WAKE        3
`define MPRC_IN_MAIN_LOW    4
`define MPRC_IN_RST_VAL     5'h0B

`endif

/* File: logic/mprc_pkg.sv */
package mprc_pkg;

  // ---------------------------------------------------------------
  // power states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SOFT_OFF,
    ST_POWER_UP,
    ST_RUN,
    ST_NOTICE,
    ST_SLEEP_RAM,
    ST_SLEEP_DISK
  } mprc_state_t;

  // ---------------------------------------------------------------
  // suspend targets requested by software
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_RAM,
    TGT_DISK,
    TGT_OFF
  } mprc_target_t;

endpackage : mprc_pkg

/* File: logic/mprc_sync.sv */
`timescale 1ns/1ps
`include "mprc_map.svh"

module mprc_sync (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // raw pins
  input  wire logic [`MPRC_IN_W-1:0] raw,
  // conditioned view
  mprc_cond_if.cond                  cond
);
  import mprc_pkg::*;

  // ---------------------------------------------------------------
  // three-stage capture, accept when stages two and three agree
  // ---------------------------------------------------------------
  logic [`MPRC_IN_W-1:0] ff1;
  logic [`MPRC_IN_W-1:0] ff2;
  logic [`MPRC_IN_W-1:0] ff3;
  logic [`MPRC_IN_W-1:0] stable;
  logic [`MPRC_IN_W-1:0] fall;
  logic [`MPRC_IN_W-1:0] rise;
  logic [`MPRC_IN_W-1:0] next_stable;
  logic [`MPRC_IN_W-1:0] next_fall;
  logic [`MPRC_IN_W-1:0] next_rise;

  always_comb begin
    for (int i = 0; i < `MPRC_IN_W; i++) begin
      next_stable[i] = (ff2[i] == ff3[i]) ? ff3[i] : stable[i];
    end
    next_fall = stable & ~next_stable;
    next_rise = ~stable & next_stable;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ff1    <= `MPRC_IN_RST_VAL;
      ff2    <= `MPRC_IN_RST_VAL;
      ff3    <= `MPRC_IN_RST_VAL;
      stable <= `MPRC_IN_RST_VAL;
      fall   <= '0;
      rise   <= '0;
    end else begin
      ff1    <= raw;
      ff2    <= ff1;
      ff3    <= ff2;
      stable <= next_stable;
      fall   <= next_fall;
      rise   <= next_rise;
    end
  end

  assign cond.level = stable;
  assign cond.fall  = fall;
  assign cond.rise  = rise;

endmodule : mprc_sync

/* File: logic/mprc_top.sv */
// Function
// - power button falling edge leaves soft-off
// - reset button active low, edge triggered
// - one reset per edge, not held
// - carrier reset output driven active low
// - reset on button, supply, main, watchdog, software
// - suspend notice low before suspend entry
// - ram sleep output low only in ram sleep
// - disk sleep output low only in disk sleep
// - soft-off output shows soft-off state
// - watchdog output high after timeout until cleared, timeout wins over clear
// - pcie wake falling edge wakes system
`timescale 1ns/1ps
`include "mprc_map.svh"

module mprc_top #(
  parameter int RESET_PULSE_US = `MPRC_RST_PULSE_US
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // carrier pins
  input  wire logic                  power_button_n,
  input  wire logic                  reset_button_n,
  input  wire logic                  supply_good,
  input  wire logic                  pcie_wake_n,
  input  wire logic                  main_supply_low,
  // on-chip requests
  input  wire logic                  watchdog_timeout,
  input  wire logic                  watchdog_clear,
  input  wire logic                  sw_reset_req,
  input  wire logic                  sleep_req,
  input  wire mprc_pkg::mprc_target_t sleep_target,
  // carrier outputs
  output logic                       carrier_reset_n,
  output logic                       suspend_imminent_n,
  output logic                       sleep_ram_n,
  output logic                       sleep_disk_n,
  output logic                       soft_off_n,
  output logic                       watchdog_expired_out,
  output mprc_pkg::mprc_state_t      power_state
);
  import mprc_pkg::*;

  // ---------------------------------------------------------------
  // timing counts
  // ---------------------------------------------------------------
  localparam logic [`MPRC_RST_CNT_W-1:0] RST_CYC =
    `MPRC_RST_CNT_W'(RESET_PULSE_US * `MPRC_CLK_MHZ);
  localparam logic [`MPRC_NTC_CNT_W-1:0] NTC_CYC =
    `MPRC_NTC_CNT_W'(`MPRC_NOTICE_US * `MPRC_CLK_MHZ);

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  mprc_cond_if cond_bus ();
  logic [`MPRC_IN_W-1:0] raw_in;

  assign raw_in = {main_supply_low, pcie_wake_n, supply_good,
                   reset_button_n, power_button_n};

  mprc_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (raw_in),
    .cond    (cond_bus.cond)
  );

  logic pwr_fall;
  logic rst_fall;
  logic supply_ok;
  logic supply_fall;
  logic wake_fall;
  logic main_low;
  logic main_rise;

  assign pwr_fall    = cond_bus.fall[`MPRC_IN_PWR];
  assign rst_fall    = cond_bus.fall[`MPRC_IN_RST];
  assign supply_ok   = cond_bus.level[`MPRC_IN_SUPPLY];
  assign supply_fall = cond_bus.fall[`MPRC_IN_SUPPLY];
  assign wake_fall   = cond_bus.fall[`MPRC_IN_WAKE];
  assign main_low    = cond_bus.level[`MPRC_IN_MAIN_LOW];
  assign main_rise   = cond_bus.rise[`MPRC_IN_MAIN_LOW];

  // ---------------------------------------------------------------
  // state and counters
  // ---------------------------------------------------------------
  mprc_state_t                state;
  mprc_state_t                next_state;
  mprc_target_t               target;
  mprc_target_t               next_target;
  logic [`MPRC_RST_CNT_W-1:0] rst_cnt;
  logic [`MPRC_RST_CNT_W-1:0] next_rst_cnt;
  logic [`MPRC_NTC_CNT_W-1:0] ntc_cnt;
  logic [`MPRC_NTC_CNT_W-1:0] next_ntc_cnt;
  logic                       wdt_flag;
  logic                       next_wdt_flag;
  logic                       reset_trigger;
  logic                       supply_bad;

  assign supply_bad    = !supply_ok || main_low;
  assign reset_trigger = rst_fall || supply_fall || main_rise ||
                         watchdog_timeout || sw_reset_req;

  always_comb begin
    next_state    = state;
    next_target   = target;
    next_ntc_cnt  = ntc_cnt;
    next_rst_cnt  = rst_cnt;
    next_wdt_flag = wdt_flag;
    if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - 1'b1;
    end
    if (reset_trigger && state == ST_RUN) begin
      next_rst_cnt = RST_CYC;
    end
    if (watchdog_clear) begin
      next_wdt_flag = 1'b0;
    end
    if (watchdog_timeout) begin
      next_wdt_flag = 1'b1;
    end
    unique case (state)
      ST_SOFT_OFF: begin
        if (pwr_fall || wake_fall) begin
          next_state = ST_POWER_UP;
        end
      end
      ST_POWER_UP: begin
        if (!supply_bad) begin
          next_state   = ST_RUN;
          next_rst_cnt = RST_CYC;
        end
      end
      ST_RUN: begin
        if (sleep_req || pwr_fall) begin
          next_state   = ST_NOTICE;
          next_target  = sleep_req ? sleep_target : TGT_OFF;
          next_ntc_cnt = NTC_CYC;
        end
      end
      ST_NOTICE: begin
        if (ntc_cnt != '0) begin
          next_ntc_cnt = ntc_cnt - 1'b1;
        end else begin
          unique case (target)
            TGT_RAM:  next_state = ST_SLEEP_RAM;
            TGT_DISK: next_state = ST_SLEEP_DISK;
            TGT_OFF:  next_state = ST_SOFT_OFF;
            default:  next_state = ST_SOFT_OFF;
          endcase
        end
      end
      ST_SLEEP_RAM, ST_SLEEP_DISK: begin
        if (pwr_fall || wake_fall) begin
          next_state = ST_POWER_UP;
        end
      end
      default: next_state = ST_SOFT_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= ST_SOFT_OFF;
      target   <= TGT_OFF;
      rst_cnt  <= '0;
      ntc_cnt  <= '0;
      wdt_flag <= 1'b0;
    end else begin
      state    <= next_state;
      target   <= next_target;
      rst_cnt  <= next_rst_cnt;
      ntc_cnt  <= next_ntc_cnt;
      wdt_flag <= next_wdt_flag;
    end
  end

  // ---------------------------------------------------------------
  // registered pin outputs
  // ---------------------------------------------------------------
  logic next_carrier_reset_n;
  logic next_suspend_imminent_n;
  logic next_sleep_ram_n;
  logic next_sleep_disk_n;
  logic next_soft_off_n;

  always_comb begin
    next_carrier_reset_n = next_state == ST_RUN &&
                           next_rst_cnt == '0 && !supply_bad;
    next_suspend_imminent_n = next_state == ST_RUN ||
                              next_state == ST_POWER_UP;
    next_sleep_ram_n  = next_state != ST_SLEEP_RAM;
    next_sleep_disk_n = next_state != ST_SLEEP_DISK;
    next_soft_off_n   = next_state != ST_SOFT_OFF;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carrier_reset_n      <= 1'b0;
      suspend_imminent_n   <= 1'b0;
      sleep_ram_n          <= 1'b1;
      sleep_disk_n         <= 1'b1;
      soft_off_n           <= 1'b0;
      watchdog_expired_out <= 1'b0;
      power_state          <= ST_SOFT_OFF;
    end else begin
      carrier_reset_n      <= next_carrier_reset_n;
      suspend_imminent_n   <= next_suspend_imminent_n;
      sleep_ram_n          <= next_sleep_ram_n;
      sleep_disk_n         <= next_sleep_disk_n;
      soft_off_n           <= next_soft_off_n;
      watchdog_expired_out <= next_wdt_flag;
      power_state          <= next_state;
    end
  end

endmodule : mprc_top

/* File: sim/mprc_carrier.sv */
`timescale 1ns/1ps

module mprc_carrier (
  // bench commands
  input  wire logic press_power,
  input  wire logic press_reset,
  input  wire logic press_wake,
  input  wire logic supply_fail,
  input  wire logic main_low,
  // module output
  input  wire logic sleep_ram_n,
  // pins
  output logic      power_button_n,
  output logic      reset_button_n,
  output logic      pcie_wake_n,
  output logic      supply_good,
  output logic      main_supply_low,
  output logic      atx_supply_on
);
  assign atx_supply_on   = !sleep_ram_n;
  assign supply_good     = !atx_supply_on && !supply_fail;
  assign power_button_n  = !press_power;
  assign reset_button_n  = !press_reset;
  assign pcie_wake_n     = !press_wake;
  assign main_supply_low = main_low;
endmodule : mprc_carrier

/* File: sim/mprc_chk.sv */
`timescale 1ns/1ps

module mprc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // inputs
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic watchdog_timeout,
  input wire logic watchdog_clear,
  input wire logic sw_reset_req,
  input wire logic sleep_req,
  // outputs
  input wire logic carrier_reset_n,
  input wire logic suspend_imminent_n,
  input wire logic sleep_ram_n,
  input wire logic sleep_disk_n,
  input wire logic soft_off_n,
  input wire logic watchdog_expired_out,
  // state
  input wire mprc_pkg::mprc_state_t power_state
);
  import mprc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_wd_set: assert property (
    watchdog_timeout |=> watchdog_expired_out) else $error("wd not set");
  a_wd_clear: assert property (
    watchdog_clear && !watchdog_timeout |=> !watchdog_expired_out)
    else $error("wd not cleared");
  a_ram_level: assert property (
    sleep_ram_n == (power_state != ST_SLEEP_RAM)) else $error("ram out");
  a_disk_level: assert property (
    sleep_disk_n == (power_state != ST_SLEEP_DISK)) else $error("disk out");
  a_off_level: assert property (
    soft_off_n == (power_state != ST_SOFT_OFF)) else $error("off out");
  a_notice_first: assert property (
    power_state == ST_RUN && sleep_req |=>
    power_state == ST_NOTICE && !suspend_imminent_n) else $error("notice");
  a_sw_reset: assert property (
    power_state == ST_RUN && sw_reset_req |=> !carrier_reset_n)
    else $error("sw reset missed");
  a_power_up: assert property (
    power_state == ST_SOFT_OFF && $fell(power_button_n) ##1
    !power_button_n [*4] |-> ##[0:2] power_state != ST_SOFT_OFF)
    else $error("no power up");
  a_button_reset: assert property (
    power_state == ST_RUN && $fell(reset_button_n) ##1
    !reset_button_n [*4] |-> ##[0:2] !carrier_reset_n)
    else $error("button reset missed");

  c_ram: cover property (power_state == ST_SLEEP_RAM);
  c_disk: cover property (power_state == ST_SLEEP_DISK);
  c_release: cover property ($rose(carrier_reset_n));
endmodule : mprc_chk

bind mprc_top mprc_chk u_chk (.clk, .reset_n, .power_button_n,
  .reset_button_n, .watchdog_timeout, .watchdog_clear, .sw_reset_req,
  .sleep_req, .carrier_reset_n, .suspend_imminent_n, .sleep_ram_n,
  .sleep_disk_n, .soft_off_n, .watchdog_expired_out, .power_state);

/* File: sim/tb.sv */
`timescale 1ns/1ps

module tb;
  import mprc_pkg::*;
  localparam int RST_US = 2;
  logic clk, reset_n, press_power, press_reset, press_wake;
  logic supply_fail, main_low, power_button_n, reset_button_n;
  logic supply_good, pcie_wake_n, main_supply_low, atx_supply_on;
  logic watchdog_timeout, watchdog_clear, sw_reset_req, sleep_req;
  logic carrier_reset_n, suspend_imminent_n, sleep_ram_n;
  logic sleep_disk_n, soft_off_n, watchdog_expired_out;
  mprc_target_t sleep_target;
  mprc_state_t  power_state;
  int           err_count, total_checks;

  mprc_top #(.RESET_PULSE_US(RST_US)) DUT (.clk, .reset_n,
    .power_button_n, .reset_button_n, .supply_good, .pcie_wake_n,
    .main_supply_low, .watchdog_timeout, .watchdog_clear, .sw_reset_req,
    .sleep_req, .sleep_target, .carrier_reset_n, .suspend_imminent_n,
    .sleep_ram_n, .sleep_disk_n, .soft_off_n, .watchdog_expired_out,
    .power_state);
  mprc_carrier u_carrier (.press_power, .press_reset, .press_wake,
    .supply_fail, .main_low, .sleep_ram_n, .power_button_n,
    .reset_button_n, .pcie_wake_n, .supply_good, .main_supply_low,
    .atx_supply_on);

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task chk(input string n, input logic [2:0] e, input logic [2:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  task test_done;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task wait_st(input mprc_state_t s);
    int n;
    n = 0;
    #1;
    while (power_state !== s && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("power_state", s, power_state);
    if (n == 3000) test_done;
  endtask : wait_st

  task settle;
    repeat (RST_US * 50 + 10) @(posedge clk);
    #1 chk("carrier_reset_n", 1, carrier_reset_n);
  endtask : settle

  task press(input bit wake);
    @(posedge clk);
    press_wake  <= wake;
    press_power <= !wake;
    repeat (8) @(posedge clk);
    press_wake  <= 0;
    press_power <= 0;
  endtask : press

  task t_power_up;
    press(0);
    wait_st(ST_RUN);
    chk("soft_off_n", 1, soft_off_n);
    settle;
  endtask : t_power_up

  task t_button;
    @(posedge clk) press_reset <= 1;
    repeat (10) @(posedge clk);
    #1 chk("carrier_reset_n", 0, carrier_reset_n);
    settle;
    @(posedge clk) press_reset <= 0;
  endtask : t_button

  task t_watchdog;
    @(posedge clk) watchdog_timeout <= 1;
    @(posedge clk) watchdog_timeout <= 0;
    @(posedge clk) #1 chk("wd_out", 1, watchdog_expired_out);
    chk("carrier_reset_n", 0, carrier_reset_n);
    @(posedge clk) watchdog_clear <= 1;
    @(posedge clk) watchdog_clear <= 0;
    @(posedge clk) #1 chk("wd_out", 0, watchdog_expired_out);
    @(posedge clk);
    watchdog_timeout <= 1;
    watchdog_clear   <= 1;
    @(posedge clk);
    watchdog_timeout <= 0;
    watchdog_clear   <= 0;
    @(posedge clk) #1 chk("wd_out", 1, watchdog_expired_out);
    settle;
    @(posedge clk) sw_reset_req <= 1;
    @(posedge clk) sw_reset_req <= 0;
    #1 chk("carrier_reset_n", 0, carrier_reset_n);
    settle;
  endtask : t_watchdog

  task t_supply(input bit main);
    @(posedge clk);
    supply_fail <= !main;
    main_low    <= main;
    repeat (10) @(posedge clk);
    #1 chk("carrier_reset_n", 0, carrier_reset_n);
    @(posedge clk);
    supply_fail <= 0;
    main_low    <= 0;
    settle;
  endtask : t_supply

  task t_sleep(input mprc_target_t t, input mprc_state_t s, input bit w);
    @(posedge clk);
    sleep_req    <= 1;
    sleep_target <= t;
    @(posedge clk) sleep_req <= 0;
    #1 chk("suspend_imminent_n", 0, suspend_imminent_n);
    wait_st(s);
    chk("sleep_ram_n", s != ST_SLEEP_RAM, sleep_ram_n);
    chk("sleep_disk_n", s != ST_SLEEP_DISK, sleep_disk_n);
    chk("soft_off_n", s != ST_SOFT_OFF, soft_off_n);
    chk("atx_supply_on", s == ST_SLEEP_RAM, atx_supply_on);
    press(w);
    wait_st(ST_RUN);
    settle;
  endtask : t_sleep

  task t_off_button;
    press(0);
    wait_st(ST_SOFT_OFF);
    chk("soft_off_n", 0, soft_off_n);
    chk("suspend_imminent_n", 0, suspend_imminent_n);
    press(1);
    wait_st(ST_RUN);
    settle;
  endtask : t_off_button

  task t_reset_mid;
    chk("wd_out", 1, watchdog_expired_out);
    @(posedge clk) reset_n <= 0;
    repeat (3) @(posedge clk);
    #1 chk("carrier_reset_n", 0, carrier_reset_n);
    chk("wd_out", 0, watchdog_expired_out);
    @(posedge clk) reset_n <= 1;
    @(posedge clk) #1 chk("power_state", ST_SOFT_OFF, power_state);
    chk("soft_off_n", 0, soft_off_n);
    @(posedge clk) #1 chk("sleep_ram_n", 1, sleep_ram_n);
    chk("carrier_reset_n", 0, carrier_reset_n);
    t_power_up;
  endtask : t_reset_mid

  initial begin
    {reset_n, press_power, press_reset, press_wake, supply_fail} = 0;
    {main_low, watchdog_timeout, watchdog_clear, sw_reset_req} = 0;
    sleep_req    = 0;
    sleep_target = TGT_RAM;
    repeat (12) @(posedge clk);
    #1 chk("soft_off_n", 0, soft_off_n);
    chk("wd_out", 0, watchdog_expired_out);
    @(posedge clk) reset_n <= 1;
    t_power_up;
    t_button;
    t_watchdog;
    t_supply(0);
    t_supply(1);
    t_sleep(TGT_RAM, ST_SLEEP_RAM, 1);
    t_sleep(TGT_DISK, ST_SLEEP_DISK, 0);
    t_sleep(TGT_OFF, ST_SOFT_OFF, 0);
    t_off_button;
    t_reset_mid;
    test_done;
  end
endmodule : tb
